// *** hw/epdsp_consts.svh ***
`ifndef EPDSP_CONSTS_SVH
`define EPDSP_CONSTS_SVH
// Command codes
`define EPDSP_CMD_GATE_LINES   8'h01
`define EPDSP_CMD_GATE_VOLT    8'h03
`define EPDSP_CMD_SOURCE_VOLT  8'h04
`define EPDSP_CMD_SLEEP        8'h10
`define EPDSP_CMD_BREAK_DETECT 8'h23
// Power-on values of the settings
`define EPDSP_GATE_LO_RST      8'hf9
`define EPDSP_GATE_HI_RST      3'h0
`define EPDSP_VGH_RST          5'h10
`define EPDSP_VGL_RST          4'ha
`define EPDSP_VSRC_RST         5'h19
`define EPDSP_SLEEP_RST        1'b0
// Frame lengths in bits
`define EPDSP_BITS_4WIRE       4'h8
`define EPDSP_BITS_3WIRE       4'h9
// Temperature layout
`define EPDSP_TEMP_SIGN        11
`define EPDSP_TEMP_FRAC_W      4
// Controller register byte offsets
`define EPDSP_OFS_CTRL         12'h000
`define EPDSP_OFS_TX           12'h004
`define EPDSP_OFS_STATUS       12'h008
// Controller field positions
`define EPDSP_CTRL_3WIRE       0
`define EPDSP_CTRL_CLEAR       1
`define EPDSP_TX_DC            8
`define EPDSP_ST_PENDING       0
`define EPDSP_ST_BUSY          1
// Serial clock timing
`define EPDSP_SCLK_NS          64
`define EPDSP_PCLK_NS          8
`define EPDSP_HALF_CYC         ((`EPDSP_SCLK_NS / `EPDSP_PCLK_NS) / 2)
`endif

// *** hw/epdsp_device.sv ***
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "epdsp_consts.svh"
// Operation
// - Link ignored unless chip select low
// - 4-wire: dc high data, low command
// - Hardware clear low resets device state
// - Busy high during waveform or sensor
// - Host sends nothing while busy high
// - Format pin low 4-wire, high 3-wire
// - Pad zero clock, pad one data
// - 4-wire: eight bits, MSB first, rising
// - Host holds dc steady per byte
// - Finished byte routed by command/data
// - 3-wire: host ties dc low
// - 3-wire: flag then eight bits MSB first
// - 3-wire: flag 0 command, 1 data
// - Temperature is 12-bit signed sixteenths
// - Break detection holds busy until done
// - Host reads status after detection
// - Command 01 sets gate line count
// - Command 03 sets gate voltages
// - Command 04 sets source voltage
// - Command 10 bit zero, default normal
// - Bit zero one enters deep sleep
module epdsp_device #(
    parameter int BREAK_CYCLES = 64
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // Serial link
    epdsp_link_if.device               link,
    // Received stream
    output logic                       cmd_valid,
    output epdsp_pkg::epdsp_byte_type  cmd_byte,
    output logic                       data_valid,
    output epdsp_pkg::epdsp_byte_type  data_byte,
    // Settings
    output logic [10:0]                gate_lines,
    output logic [4:0]                 gate_high_rail,
    output logic [3:0]                 gate_low_rail,
    output logic [4:0]                 source_high_rail,
    output logic                       deep_sleep,
    output logic                       hw_clear_active,
    // Activity and panel check
    input  wire logic                  waveform_active,
    input  wire logic                  sensor_active,
    input  wire logic                  panel_broken,
    output logic                       break_flag,
    // Temperature
    input  wire logic [11:0]           temp_raw,
    output logic                       temp_negative,
    output logic [7:0]                 temp_whole,
    output logic [3:0]                 temp_frac
);
    import epdsp_pkg::*;

    initial begin
        if (BREAK_CYCLES < 1 || BREAK_CYCLES > 65535) begin
            $error("BREAK_CYCLES out of range");
        end
    end

    // ********
    // Pin synchronisers
    // ********
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic       clk_prev;
    logic [5:0] pins;

    assign pins = {link.hw_clear_n, link.bus_format_select, link.dc,
                   link.data_pad, link.clock_pad, link.cs_n};

    // Two flops per pin; reset values mimic an idle link
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 6'h21;
            sync_b <= 6'h21;
        end else begin
            sync_a <= pins;
            sync_b <= sync_a;
        end
    end

    logic cs_n_s;
    logic sclk_s;
    logic serial_data_in_s;
    logic dc_s;
    logic three_wire;
    logic clear;
    assign cs_n_s     = sync_b[0];
    assign sclk_s     = sync_b[1];
    assign serial_data_in_s     = sync_b[2];
    assign dc_s       = sync_b[3];
    assign three_wire = sync_b[4];
    assign clear      = !sync_b[5];

    // Third flop only for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= sclk_s;
        end
    end

    logic rise;
    assign rise = sclk_s && !clk_prev && !cs_n_s;

    // ********
    // Frame shifter
    // ********
    logic [8:0] shreg;
    logic [3:0] nbits;
    logic [3:0] frame_len;
    logic       frame_done;
    logic [8:0] next_shreg;
    assign frame_len  = three_wire ? `EPDSP_BITS_3WIRE : `EPDSP_BITS_4WIRE;
    assign next_shreg = {shreg[7:0], serial_data_in_s};
    assign frame_done = rise && (nbits == frame_len - 4'h1);

    // Deselect drops any partial frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nbits <= 4'h0;
            shreg <= 9'h000;
        end else if (clear || cs_n_s) begin
            nbits <= 4'h0;
        end else if (rise) begin
            shreg <= next_shreg;
            nbits <= frame_done ? 4'h0 : nbits + 4'h1;
        end
    end

    logic is_data;
    // 4-wire takes the pin, 3-wire the leading flag
    assign is_data = three_wire ? shreg[7] : dc_s;

    // ********
    // Byte routing
    // ********
    logic [1:0] param_idx;
    logic       got_cmd;
    logic       got_data;
    assign got_cmd  = frame_done && !is_data;
    assign got_data = frame_done && is_data;

    // Strobes toward command decode and RAM data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_valid  <= 1'b0;
            data_valid <= 1'b0;
            cmd_byte   <= 8'h00;
            data_byte  <= 8'h00;
        end else begin
            cmd_valid  <= got_cmd && !clear;
            data_valid <= got_data && !clear;
            if (clear) begin
                cmd_byte <= 8'h00;
            end else if (got_cmd) begin
                cmd_byte <= next_shreg[7:0];
            end
            if (got_data) begin
                data_byte <= next_shreg[7:0];
            end
        end
    end

    // Parameter position restarts at each command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param_idx <= 2'h0;
        end else if (clear || got_cmd) begin
            param_idx <= 2'h0;
        end else if (got_data && param_idx != 2'h3) begin
            param_idx <= param_idx + 2'h1;
        end
    end

    // ********
    // Settings
    // ********
    logic [7:0] pb;
    assign pb = next_shreg[7:0];

    // Only the listed fields are kept; extra bytes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_lines       <= {`EPDSP_GATE_HI_RST, `EPDSP_GATE_LO_RST};
            gate_high_rail   <= `EPDSP_VGH_RST;
            gate_low_rail    <= `EPDSP_VGL_RST;
            source_high_rail <= `EPDSP_VSRC_RST;
            deep_sleep       <= `EPDSP_SLEEP_RST;
        end else if (clear) begin
            gate_lines       <= {`EPDSP_GATE_HI_RST, `EPDSP_GATE_LO_RST};
            gate_high_rail   <= `EPDSP_VGH_RST;
            gate_low_rail    <= `EPDSP_VGL_RST;
            source_high_rail <= `EPDSP_VSRC_RST;
            deep_sleep       <= `EPDSP_SLEEP_RST;
        end else if (got_data) begin
            unique case (cmd_byte)
                `EPDSP_CMD_GATE_LINES: begin
                    if (param_idx == 2'h0) gate_lines[7:0] <= pb;
                    if (param_idx == 2'h1) gate_lines[10:8] <= pb[2:0];
                end
                `EPDSP_CMD_GATE_VOLT: begin
                    if (param_idx == 2'h0) gate_high_rail <= pb[4:0];
                    if (param_idx == 2'h1) gate_low_rail <= pb[3:0];
                end
                `EPDSP_CMD_SOURCE_VOLT: begin
                    if (param_idx == 2'h0) source_high_rail <= pb[4:0];
                end
                `EPDSP_CMD_SLEEP: begin
                    if (param_idx == 2'h0) deep_sleep <= pb[0];
                end
                default: begin
                end
            endcase
        end
    end

    // ********
    // Break detection and busy
    // ********
    logic [15:0] brk_cnt;
    logic        brk_run;

    // Detection runs a fixed time then samples the panel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_run    <= 1'b0;
            brk_cnt    <= 16'h0000;
            break_flag <= 1'b0;
        end else if (clear) begin
            brk_run    <= 1'b0;
            break_flag <= 1'b0;
        end else if (got_cmd && next_shreg[7:0] == `EPDSP_CMD_BREAK_DETECT) begin
            brk_run <= 1'b1;
            brk_cnt <= 16'(BREAK_CYCLES - 1);
        end else if (brk_run) begin
            if (brk_cnt == 16'h0000) begin
                brk_run    <= 1'b0;
                break_flag <= panel_broken;
            end else begin
                brk_cnt <= brk_cnt - 16'h0001;
            end
        end
    end

    // Busy is registered, so it trails its causes by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.busy       <= 1'b0;
            hw_clear_active <= 1'b0;
        end else begin
            link.busy       <= waveform_active || sensor_active || brk_run;
            hw_clear_active <= clear;
        end
    end

    // ********
    // Temperature
    // ********
    // Whole part keeps bit 11, so it stays signed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_negative <= 1'b0;
            temp_whole    <= 8'h00;
            temp_frac     <= 4'h0;
        end else begin
            temp_negative <= temp_raw[`EPDSP_TEMP_SIGN];
            temp_whole    <= temp_raw[11:`EPDSP_TEMP_FRAC_W];
            temp_frac     <= temp_raw[`EPDSP_TEMP_FRAC_W-1:0];
        end
    end
endmodule

// *** hw/epdsp_host.sv ***
`timescale 1ns/1ps
`include "epdsp_consts.svh"
module epdsp_host (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    epdsp_link_if.host       link
);
    import epdsp_pkg::*;

    localparam logic [3:0] HALF = 4'(`EPDSP_HALF_CYC);

    initial begin
        if (`EPDSP_HALF_CYC < 1) begin
            $error("serial clock half period too short");
        end
    end

    // ********
    // Registers
    // ********
    logic       ctrl_3wire;
    logic       ctrl_clear;
    logic [8:0] tx_word;
    logic       pending;
    logic       busy_a;
    logic       busy_s;
    logic       wr;
    logic       start;
    logic       idle;
    assign wr = psel && penable && pready && pwrite;

    // Busy pin passes two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_a <= 1'b0;
            busy_s <= 1'b0;
        end else begin
            busy_a <= link.busy;
            busy_s <= busy_a;
        end
    end

    // Answer in the access cycle; prdata is prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            unique case (paddr)
                `EPDSP_OFS_CTRL:   prdata <= {30'h0, ctrl_clear, ctrl_3wire};
                `EPDSP_OFS_TX:     prdata <= {23'h0, tx_word};
                `EPDSP_OFS_STATUS: prdata <= {30'h0, busy_s, pending};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control; format changes are only meant between frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_3wire <= 1'b0;
            ctrl_clear <= 1'b0;
        end else if (wr && paddr == `EPDSP_OFS_CTRL) begin
            ctrl_3wire <= pwdata[`EPDSP_CTRL_3WIRE];
            ctrl_clear <= pwdata[`EPDSP_CTRL_CLEAR];
        end
    end

    // A write while a frame is pending is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_word <= 9'h000;
            pending <= 1'b0;
        end else if (wr && paddr == `EPDSP_OFS_TX && !pending) begin
            tx_word <= pwdata[`EPDSP_TX_DC:0];
            pending <= 1'b1;
        end else if (start) begin
            pending <= 1'b0;
        end
    end

    // ********
    // Serial sequencer
    // ********
    epdsp_state_type state;
    logic [3:0]      tick;
    logic [3:0]      left;
    logic [8:0]      sh;
    logic            tick_end;
    assign idle     = state == EPDSP_IDLE;
    assign start    = idle && pending && !busy_s;
    assign tick_end = tick == HALF - 4'h1;

    // Divider tick counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 4'h0;
        end else if (idle || tick_end) begin
            tick <= 4'h0;
        end else begin
            tick <= tick + 4'h1;
        end
    end

    // Link pins change only in the low half of the serial clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= EPDSP_IDLE;
            left           <= 4'h0;
            sh             <= 9'h000;
            link.cs_n      <= 1'b1;
            link.clock_pad <= 1'b0;
            link.data_pad  <= 1'b0;
            link.dc        <= 1'b0;
        end else begin
            unique case (state)
                EPDSP_IDLE: begin
                    if (start) begin
                        state     <= EPDSP_SELECT;
                        link.cs_n <= 1'b0;
                        link.dc   <= ctrl_3wire ? 1'b0 : tx_word[8];
                        sh        <= ctrl_3wire ? tx_word : {tx_word[7:0], 1'b0};
                        left      <= ctrl_3wire ? `EPDSP_BITS_3WIRE : `EPDSP_BITS_4WIRE;
                    end
                end
                EPDSP_SELECT: begin
                    if (tick_end) begin
                        state         <= EPDSP_LOW;
                        link.data_pad <= sh[8];
                        sh            <= {sh[7:0], 1'b0};
                    end
                end
                EPDSP_LOW: begin
                    if (tick_end) begin
                        state          <= EPDSP_HIGH;
                        link.clock_pad <= 1'b1;
                        left           <= left - 4'h1;
                    end
                end
                EPDSP_HIGH: begin
                    if (tick_end) begin
                        link.clock_pad <= 1'b0;
                        if (left == 4'h0) begin
                            state <= EPDSP_RELEASE;
                        end else begin
                            state         <= EPDSP_LOW;
                            link.data_pad <= sh[8];
                            sh            <= {sh[7:0], 1'b0};
                        end
                    end
                end
                EPDSP_RELEASE: begin
                    if (tick_end) begin
                        state     <= EPDSP_IDLE;
                        link.cs_n <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Static straps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.bus_format_select <= 1'b0;
            link.hw_clear_n        <= 1'b1;
        end else begin
            link.bus_format_select <= ctrl_3wire;
            link.hw_clear_n        <= !ctrl_clear;
        end
    end
endmodule

// *** hw/epdsp_link_if.sv ***
`timescale 1ns/1ps
interface epdsp_link_if;
    logic cs_n;
    logic clock_pad;
    logic data_pad;
    logic dc;
    logic bus_format_select;
    logic hw_clear_n;
    logic busy;
    modport device (
        input  cs_n, clock_pad, data_pad, dc, bus_format_select, hw_clear_n,
        output busy
    );
    modport host (
        output cs_n, clock_pad, data_pad, dc, bus_format_select, hw_clear_n,
        input  busy
    );
endinterface

// *** hw/epdsp_pkg.sv ***
package epdsp_pkg;
    // Controller sequencer
    typedef enum logic [2:0] {
        EPDSP_IDLE,
        EPDSP_SELECT,
        EPDSP_LOW,
        EPDSP_HIGH,
        EPDSP_RELEASE
    } epdsp_state_type;
    typedef logic [7:0] epdsp_byte_type;
endpackage

// *** tb/epdsp_link_monitor.sv ***
`timescale 1ns/1ps
`include "epdsp_consts.svh"
module epdsp_link_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link wires
    input wire logic cs_n,
    input wire logic clock_pad,
    input wire logic data_pad,
    input wire logic dc,
    input wire logic bus_format_select,
    input wire logic hw_clear_n,
    input wire logic busy
);
    // ********
    // Bit counting per frame
    // ********
    logic [3:0] rise_count;
    logic       clock_q;

    // Previous clock level for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_q <= 1'b0;
        end else begin
            clock_q <= clock_pad;
        end
    end

    // Cleared while deselected; no carry-over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_count <= 4'h0;
        end else if (cs_n) begin
            rise_count <= 4'h0;
        end else if (clock_pad && !clock_q) begin
            rise_count <= rise_count + 4'h1;
        end
    end

    // ********
    // Properties
    // ********
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_high_phase;
        clock_pad[*4] ##1 !clock_pad;
    endsequence

    sequence s_in_frame;
        !cs_n && !$past(cs_n);
    endsequence

    a_idle_clock_low: assert property (cs_n |-> !clock_pad)
        else $error("clock outside frame");
    a_high_phase: assert property ($rose(clock_pad) |-> s_high_phase)
        else $error("clock high phase length");
    a_data_hold: assert property ($rose(clock_pad) |-> $stable(data_pad)[*4])
        else $error("data moved in high phase");
    a_dc_steady: assert property (s_in_frame |-> $stable(dc))
        else $error("dc moved in frame");
    a_dc_tied_low: assert property ((bus_format_select && !cs_n) |-> !dc)
        else $error("dc high in 3-wire frame");
    a_format_fixed: assert property (s_in_frame |-> $stable(bus_format_select))
        else $error("format moved in frame");
    a_bit_count: assert property ($rose(cs_n) |-> rise_count ==
        (bus_format_select ? `EPDSP_BITS_3WIRE : `EPDSP_BITS_4WIRE))
        else $error("wrong clock rise count");
    a_no_start_busy: assert property (busy[*6] |-> !$fell(cs_n))
        else $error("frame started while busy");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "epdsp_consts.svh"
module tb;
    import epdsp_pkg::*;
    // ********
    // Signals
    // ********
    localparam int BRK = 4;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [11:0]    paddr = 12'h000;
    logic [31:0]    pwdata = 32'h0;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           cmd_valid;
    logic           data_valid;
    epdsp_byte_type cmd_byte;
    epdsp_byte_type data_byte;
    logic [10:0]    gate_lines;
    logic [4:0]     gate_high_rail;
    logic [3:0]     gate_low_rail;
    logic [4:0]     source_high_rail;
    logic           deep_sleep;
    logic           hw_clear_active;
    logic           waveform_active = 1'b0;
    logic           sensor_active = 1'b0;
    logic           panel_broken = 1'b0;
    logic           break_flag;
    logic [11:0]    temp_raw = 12'h000;
    logic           temp_negative;
    logic [7:0]     temp_whole;
    logic [3:0]     temp_frac;
    int             err_count = 0;
    int             tests_run = 0;
    int             seed = 58;
    int             cycles = 0;
    int             run = 0;
    int             last_run = 0;
    logic [8:0]     recv[$];
    logic [31:0]    q;
    logic [10:0]    m_gate;
    logic [4:0]     m_vgh;
    logic [3:0]     m_vgl;
    logic [4:0]     m_vsrc;
    logic           m_sleep;
    logic [7:0]     m_cmd;
    int             m_idx;
    logic [7:0]     cmds[4] = '{8'h01, 8'h03, 8'h04, 8'h10};
    logic [11:0]    temps[4] = '{12'h7f0, 12'he70, 12'hc92, 12'h002};

    always #4 pclk = ~pclk;

    epdsp_link_if link_if();
    epdsp_host epdsp_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .link(link_if));
    epdsp_device #(.BREAK_CYCLES(BRK)) epdsp_device_inst (.pclk, .presetn, .link(link_if),
        .cmd_valid, .cmd_byte, .data_valid, .data_byte, .gate_lines, .gate_high_rail,
        .gate_low_rail, .source_high_rail, .deep_sleep, .hw_clear_active,
        .waveform_active, .sensor_active, .panel_broken, .break_flag, .temp_raw,
        .temp_negative, .temp_whole, .temp_frac);
    epdsp_link_monitor epdsp_link_monitor_inst (.pclk, .presetn,
        .cs_n(link_if.cs_n), .clock_pad(link_if.clock_pad), .data_pad(link_if.data_pad),
        .dc(link_if.dc), .bus_format_select(link_if.bus_format_select),
        .hw_clear_n(link_if.hw_clear_n), .busy(link_if.busy));

    // Received bytes, busy run length and watchdog; sampled mid-cycle to avoid races
    always @(negedge pclk) begin
        cycles++;
        if (cmd_valid === 1'b1) recv.push_back({1'b0, cmd_byte});
        if (data_valid === 1'b1) recv.push_back({1'b1, data_byte});
        if (link_if.busy === 1'b1) run++;
        else begin
            if (run != 0) last_run = run;
            run = 0;
        end
        if (cycles > 60000) begin
            err_count++;
            finish_test();
        end
    end

    // ********
    // Tasks
    // ********
    task automatic finish_test();
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic model_reset();
        m_gate = {`EPDSP_GATE_HI_RST, `EPDSP_GATE_LO_RST};
        m_vgh = `EPDSP_VGH_RST;
        m_vgl = `EPDSP_VGL_RST;
        m_vsrc = `EPDSP_VSRC_RST;
        m_sleep = `EPDSP_SLEEP_RST;
        m_cmd = 8'h00;
        m_idx = 0;
    endtask

    // Parameter bytes fill fields in order; a command restarts the count
    task automatic apply(input logic dc, input logic [7:0] b);
        if (!dc) begin
            m_cmd = b;
            m_idx = 0;
        end else begin
            case (m_cmd)
                `EPDSP_CMD_GATE_LINES: if (m_idx == 0) m_gate[7:0] = b;
                    else if (m_idx == 1) m_gate[10:8] = b[2:0];
                `EPDSP_CMD_GATE_VOLT: if (m_idx == 0) m_vgh = b[4:0];
                    else if (m_idx == 1) m_vgl = b[3:0];
                `EPDSP_CMD_SOURCE_VOLT: if (m_idx == 0) m_vsrc = b[4:0];
                `EPDSP_CMD_SLEEP: if (m_idx == 0) m_sleep = b[0];
                default: ;
            endcase
            m_idx++;
        end
    endtask

    // One APB transfer; only the watchdog bounds the wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        chk("pslverr", 0, pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tx(input logic dc, input logic [7:0] b);
        apb(1'b1, `EPDSP_OFS_TX, {23'h0, dc, b});
        apply(dc, b);
    endtask

    task automatic done(input logic dc, input logic [7:0] b);
        while (link_if.cs_n !== 1'b0) @(negedge pclk);
        while (link_if.cs_n !== 1'b1) @(negedge pclk);
        repeat (2) @(negedge pclk);
        chk("stream", {23'h0, dc, b}, recv.size() ? {23'h0, recv.pop_front()} : 32'hx);
    endtask

    task automatic send(input logic dc, input logic [7:0] b);
        tx(dc, b);
        done(dc, b);
    endtask

    task automatic settings();
        chk("gate_lines", m_gate, gate_lines);
        chk("gate_high", m_vgh, gate_high_rail);
        chk("gate_low", m_vgl, gate_low_rail);
        chk("source", m_vsrc, source_high_rail);
        chk("sleep", m_sleep, deep_sleep);
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        model_reset();
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        settings();
        apb(1'b0, `EPDSP_OFS_STATUS, 32'h0);
        chk("status", 32'h0, q);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped", 32'h0, q);
        // Every settings command (all but break detection) in both formats, with a surplus byte each time
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, `EPDSP_OFS_CTRL, f);
            repeat (2) @(negedge pclk);
            chk("format", f, link_if.bus_format_select);
            foreach (cmds[i]) begin
                send(1'b0, cmds[i]);
                repeat (3) send(1'b1, 8'($random(seed)));
                settings();
            end
            send(1'b0, `EPDSP_CMD_SLEEP);
            send(1'b1, 8'h01);
            chk("deep_sleep", 1, deep_sleep);
        end
        // Activity raises busy and holds back a queued byte
        @(posedge pclk);
        waveform_active <= 1'b1;
        repeat (4) @(negedge pclk);
        chk("busy_wave", 1, link_if.busy);
        tx(1'b0, `EPDSP_CMD_SOURCE_VOLT);
        repeat (20) @(negedge pclk);
        chk("held_frame", 1, link_if.cs_n);
        apb(1'b0, `EPDSP_OFS_STATUS, 32'h0);
        chk("status_busy", 32'h3, q);
        waveform_active <= 1'b0;
        sensor_active <= 1'b1;
        repeat (4) @(negedge pclk);
        chk("busy_sensor", 1, link_if.busy);
        @(posedge pclk);
        sensor_active <= 1'b0;
        done(1'b0, `EPDSP_CMD_SOURCE_VOLT);
        send(1'b1, 8'($random(seed)));
        settings();
        // Panel check with both outcomes
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            panel_broken <= k[0];
            last_run = 0;
            send(1'b0, `EPDSP_CMD_BREAK_DETECT);
            while (link_if.busy !== 1'b0) @(negedge pclk);
            chk("busy_len", BRK, last_run);
            repeat (2) @(negedge pclk);
            chk("break_flag", k, break_flag);
        end
        // Temperature layout
        foreach (temps[i]) begin
            @(posedge pclk);
            temp_raw <= (i == 3) ? 12'($random(seed)) : temps[i];
            repeat (3) @(negedge pclk);
            chk("temp_neg", temp_raw[11], temp_negative);
            chk("temp_whole", temp_raw[11:4], temp_whole);
            chk("temp_frac", temp_raw[3:0], temp_frac);
        end
        // Hardware clear restores every setting
        apb(1'b1, `EPDSP_OFS_CTRL, 32'h2);
        repeat (8) @(negedge pclk);
        chk("clear_active", 1, hw_clear_active);
        model_reset();
        settings();
        apb(1'b1, `EPDSP_OFS_CTRL, 32'h0);
        repeat (8) @(negedge pclk);
        chk("clear_done", 0, hw_clear_active);
        send(1'b0, `EPDSP_CMD_GATE_VOLT);
        send(1'b1, 8'($random(seed)));
        settings();
        finish_test();
    end
endmodule
